// File: logic/tmr_map.svh
// constants of the two-wire master receiver: status codes, reset values, timing
// assumes it is included by bare name wherever a code or a count is needed
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// ****************************************************************
// status codes
// ****************************************************************
`define TMR_ST_START 8'h08
`define TMR_ST_REP_START 8'h10
`define TMR_ST_ARB_LOST 8'h38
`define TMR_ST_ADDR_ACK 8'h40
`define TMR_ST_ADDR_NACK 8'h48
`define TMR_ST_DATA_ACK 8'h50
`define TMR_ST_DATA_NACK 8'h58
`define TMR_ST_IDLE 8'hf8

// ****************************************************************
// fields and reset values
// ****************************************************************
`define TMR_DIR_BIT 0
`define TMR_STATUS_RST 8'hf8
`define TMR_DATA_RST 8'hff
`define TMR_BIT_COUNT 4'h8

// ****************************************************************
// timing: bus bit period and link clock period in ns
// ****************************************************************
`define TMR_BIT_NS 2500
`define TMR_LINK_NS 15
// a quarter bit is a longest time per phase, so it rounds down
`define TMR_QTR_CYC ((`TMR_BIT_NS / 4) / `TMR_LINK_NS)

`endif

// File: logic/tmr_pkg.sv
// types of the two-wire master receiver
// assumes tmr_map.svh supplies the numeric constants
package tmr_pkg;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_START = 3'h1,
    CMD_ADDR = 3'h2,
    CMD_RX = 3'h3,
    CMD_STOP = 3'h4,
    CMD_STOP_START = 3'h5
  } tmr_cmd_t;

  // gray along idle -> wait free -> start -> bits -> stop
  typedef enum logic [2:0] {
    LS_IDLE = 3'h0,
    LS_WAIT_FREE = 3'h1,
    LS_START = 3'h3,
    LS_BITS = 3'h2,
    LS_STOP = 3'h6
  } tmr_lstate_t;

  typedef struct packed {
    logic flag;
    logic [7:0] status;
    logic [7:0] data;
    logic start;
    logic stop;
    logic ack;
    logic en;
    logic xmit;
    logic waiting;
    logic cmd_tgl;
    tmr_cmd_t cmd_kind;
    logic [7:0] cmd_byte;
    logic cmd_ack;
    logic dn_m;
    logic dn_s;
    logic dn_ack;
  } tmr_ref_t;

  typedef struct packed {
    logic rst_m;
    logic rst_s;
    logic tg_m;
    logic tg_s;
    logic tg_seen;
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic busy;
    tmr_lstate_t st;
    tmr_cmd_t kind;
    logic ack;
    logic [5:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [8:0] rsh;
    logic scl_oe;
    logic sda_oe;
    logic owns;
    logic [7:0] lstat;
    logic done_tgl;
  } tmr_link_t;

endpackage

// File: logic/tmr_fifo.sv
// first-in first-out buffer for received bytes, one clock domain
// assumes a synchronous active-low reset; read data come from a register stage
`timescale 1ns/1ps
module tmr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } tmr_fifo_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  tmr_fifo_state_t s_q;
  tmr_fifo_state_t s_d;
  logic push;
  logic pop;

  // ****************************************************************
  // storage; the output register adds one word beyond DEPTH
  // ****************************************************************
  assign o_in_ready = (s_q.cnt != (AW + 1)'(DEPTH));
  assign push = i_in_valid && o_in_ready;
  assign pop = (s_q.cnt != '0) && (!s_q.ov || i_out_ready);
  assign o_out_valid = s_q.ov;
  assign o_out_data = s_q.od;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[s_q.wr] <= i_in_data;
    end
  end

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
      s_d.od = mem[s_q.rd];
      s_d.ov = 1'b1;
    end else if (i_out_ready) begin
      s_d.ov = 1'b0;
    end
    s_d.cnt = s_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// File: logic/tmr_master_rx.sv
// master receiver of a byte-oriented two-wire bus, control and status as plain ports
// assumes software drives the control strobes on i_ref_clk; the bus engine runs on i_link_clk
//
// How it works
// R1 - after a start report 08; on flag clear send the read address and sample acknowledge
// R2 - after a repeated start report 10; a write address hands over to transmitter
// R3 - arbitration lost in address or not-acknowledge reports 38; no start releases the bus
// R4 - lost arbitration with start set waits for a free bus, then sends start
// R5 - acknowledged read address reports 40; next byte acknowledged per ack_enable
// R6 - not-acknowledged read address reports 48; only repeated start, stop, stop+start follow
// R7 - byte received with acknowledge reports 50 and holds the byte readable
// R8 - byte received with not-acknowledge reports 58; then repeated start, stop or both
// R9 - flag clear with stop alone sends stop and clears stop_request itself
// R10 - flag clear with start and stop sends stop then start, clears stop_request
// R11 - software clears the flag by writing one, with enable and action bits together
// R12 - the flag sets when a start, address or data byte with acknowledge completes
// R13 - each status value stands for exactly one bus and interface state
// R14 - software begins with start and enable, then waits for flag and start status
// R15 - address byte holds slave address in bits 7..1, direction in bit 0, 1 reads
// R16 - control writes only while flag set or status idle (f8); status and data stay until it clears
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_master_rx (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_ctl_write,
  input wire logic i_ctl_flag_clear,
  input wire logic i_ctl_start,
  input wire logic i_ctl_stop,
  input wire logic i_ctl_ack,
  input wire logic i_ctl_enable,
  input wire logic i_data_write,
  input wire logic [7:0] i_data_wdata,
  output logic o_completion_flag,
  output logic [7:0] o_status,
  output logic [7:0] o_data,
  output logic o_start_request,
  output logic o_stop_request,
  output logic o_ack_enable,
  output logic o_interface_enable,
  output logic o_transmitter_mode,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe
);

  tmr_pkg::tmr_ref_t r_q;
  tmr_pkg::tmr_ref_t r_d;
  tmr_pkg::tmr_link_t l_q;
  tmr_pkg::tmr_link_t l_d;
  logic fifo_in_ready;
  logic fifo_push;

  function automatic logic is_data_code(input logic [7:0] code);
    is_data_code = (code == `TMR_ST_DATA_ACK) || (code == `TMR_ST_DATA_NACK);
  endfunction

  // ****************************************************************
  // reference domain: control, status, data, completion flag
  // ****************************************************************
  always_comb begin
    tmr_pkg::tmr_cmd_t k;
    logic take;
    logic done_new;
    k = tmr_pkg::CMD_NONE;
    take = (r_q.flag || (r_q.status == `TMR_ST_IDLE)) && !r_q.waiting; // R16
    done_new = (r_q.dn_s != r_q.dn_ack);
    r_d = r_q;
    fifo_push = 1'b0;
    r_d.dn_m = l_q.done_tgl;
    r_d.dn_s = r_q.dn_m;
    if (i_data_write && take) begin
      r_d.data = i_data_wdata;
    end
    if (i_ctl_write && take) begin
      r_d.start = i_ctl_start;
      r_d.stop = i_ctl_stop;
      r_d.ack = i_ctl_ack;
      r_d.en = i_ctl_enable;
      if (!i_ctl_enable) begin
        r_d.flag = 1'b0;
        r_d.status = `TMR_STATUS_RST;
        r_d.xmit = 1'b0;
      end else if (i_ctl_flag_clear) begin // R11
        r_d.flag = 1'b0;
        if ((r_q.status == `TMR_ST_START || r_q.status == `TMR_ST_REP_START) && !i_ctl_stop) begin
          if (r_q.data[`TMR_DIR_BIT]) begin // R15
            k = tmr_pkg::CMD_ADDR; // R1
          end else begin
            r_d.xmit = 1'b1; // R2
          end
        end else if ((r_q.status == `TMR_ST_ADDR_ACK || r_q.status == `TMR_ST_DATA_ACK) &&
                     !i_ctl_start && !i_ctl_stop) begin
          k = tmr_pkg::CMD_RX; // R5 R7
        end else if (i_ctl_start && i_ctl_stop) begin
          k = tmr_pkg::CMD_STOP_START; // R10 R6 R8
        end else if (i_ctl_stop) begin
          k = tmr_pkg::CMD_STOP; // R9 R6 R8
        end else if (i_ctl_start) begin
          k = tmr_pkg::CMD_START; // R4 R14
        end else if (r_q.status == `TMR_ST_ARB_LOST) begin
          r_d.status = `TMR_ST_IDLE; // R3
        end
        if (k != tmr_pkg::CMD_NONE) begin
          r_d.cmd_kind = k;
          r_d.cmd_byte = r_q.data;
          r_d.cmd_ack = i_ctl_ack;
          r_d.cmd_tgl = !r_q.cmd_tgl;
          r_d.waiting = 1'b1;
        end
      end
    end
    // a finished byte waits here while the buffer is full, which stalls the bus engine
    if (done_new && (!is_data_code(l_q.lstat) || fifo_in_ready)) begin
      r_d.dn_ack = r_q.dn_s;
      r_d.waiting = 1'b0;
      r_d.status = l_q.lstat; // R13
      fifo_push = is_data_code(l_q.lstat);
      if (is_data_code(l_q.lstat)) begin
        r_d.data = l_q.rsh[8:1]; // R7 R8
      end
      if (r_q.cmd_kind == tmr_pkg::CMD_STOP) begin
        r_d.stop = 1'b0; // R9
        r_d.status = `TMR_ST_IDLE;
      end else begin
        if (r_q.cmd_kind == tmr_pkg::CMD_STOP_START) begin
          r_d.stop = 1'b0; // R10
        end
        r_d.flag = 1'b1; // R12
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      r_q <= '{flag: 1'b0, status: `TMR_STATUS_RST, data: `TMR_DATA_RST, start: 1'b0, stop: 1'b0,
               ack: 1'b0, en: 1'b0, xmit: 1'b0, waiting: 1'b0, cmd_tgl: 1'b0,
               cmd_kind: tmr_pkg::CMD_NONE, cmd_byte: 8'h00, cmd_ack: 1'b0,
               dn_m: 1'b0, dn_s: 1'b0, dn_ack: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign o_completion_flag = r_q.flag;
  assign o_status = r_q.status;
  assign o_data = r_q.data;
  assign o_start_request = r_q.start;
  assign o_stop_request = r_q.stop;
  assign o_ack_enable = r_q.ack;
  assign o_interface_enable = r_q.en;
  assign o_transmitter_mode = r_q.xmit;

  // ****************************************************************
  // received byte buffer
  // ****************************************************************
  tmr_fifo #(
    .WIDTH(8),
    .DEPTH(16)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(l_q.rsh[8:1]),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready),
    .o_out_data(o_rx_data)
  );

  // ****************************************************************
  // link domain: bus engine, a quarter-bit phase counter
  // ****************************************************************
  always_comb begin
    logic tick;
    logic finish;
    tick = 1'b0;
    finish = 1'b0;
    l_d = l_q;
    l_d.rst_m = i_rst_n;
    l_d.rst_s = l_q.rst_m;
    l_d.tg_m = r_q.cmd_tgl;
    l_d.tg_s = l_q.tg_m;
    l_d.scl_m = i_scl;
    l_d.scl_s = l_q.scl_m;
    l_d.sda_m = i_sda;
    l_d.sda_s = l_q.sda_m;
    l_d.sda_p = l_q.sda_s;
    if (l_q.scl_s && l_q.sda_p && !l_q.sda_s) begin
      l_d.busy = 1'b1;
    end else if (l_q.scl_s && !l_q.sda_p && l_q.sda_s) begin
      l_d.busy = 1'b0;
    end
    // a slave holding the clock low stretches the high phase
    if (l_q.st != tmr_pkg::LS_IDLE && l_q.st != tmr_pkg::LS_WAIT_FREE &&
        !(l_q.phase == 2'd2 && !l_q.scl_s)) begin
      if (l_q.qcnt == 6'(`TMR_QTR_CYC - 1)) begin
        tick = 1'b1;
        l_d.qcnt = 6'h00;
        l_d.phase = l_q.phase + 2'd1;
      end else begin
        l_d.qcnt = l_q.qcnt + 6'h01;
      end
    end
    case (l_q.st)
      tmr_pkg::LS_IDLE: begin
        if (l_q.tg_s != l_q.tg_seen) begin
          l_d.tg_seen = l_q.tg_s;
          l_d.kind = r_q.cmd_kind;
          l_d.ack = r_q.cmd_ack;
          l_d.qcnt = 6'h00;
          l_d.phase = 2'd0;
          l_d.bitn = 4'h0;
          case (r_q.cmd_kind)
            tmr_pkg::CMD_START: begin
              l_d.st = l_q.owns ? tmr_pkg::LS_START : tmr_pkg::LS_WAIT_FREE; // R4
            end
            tmr_pkg::CMD_ADDR: begin
              l_d.sh = {r_q.cmd_byte, 1'b1}; // R1
              l_d.st = tmr_pkg::LS_BITS;
            end
            tmr_pkg::CMD_RX: begin
              l_d.sh = {8'hff, !r_q.cmd_ack}; // R5 R7
              l_d.st = tmr_pkg::LS_BITS;
            end
            default: begin
              l_d.st = tmr_pkg::LS_STOP;
            end
          endcase
        end
      end
      tmr_pkg::LS_WAIT_FREE: begin
        if (!l_q.busy) begin
          l_d.st = tmr_pkg::LS_START; // R4 R10
          l_d.qcnt = 6'h00;
          l_d.phase = 2'd0;
        end
      end
      tmr_pkg::LS_START: begin
        if (tick) begin
          case (l_q.phase)
            2'd0: l_d.sda_oe = 1'b0;
            2'd1: l_d.scl_oe = 1'b0;
            2'd2: l_d.sda_oe = 1'b1;
            default: begin
              l_d.scl_oe = 1'b1;
              l_d.owns = 1'b1;
              l_d.lstat = l_q.owns ? `TMR_ST_REP_START : `TMR_ST_START; // R1 R2
              finish = 1'b1;
            end
          endcase
        end
      end
      tmr_pkg::LS_BITS: begin
        if (tick) begin
          case (l_q.phase)
            2'd0: l_d.sda_oe = !l_q.sh[8];
            2'd1: l_d.scl_oe = 1'b0;
            2'd2: begin
              l_d.rsh = {l_q.rsh[7:0], l_q.sda_s};
              if (l_q.sh[8] && !l_q.sda_s &&
                  ((l_q.kind == tmr_pkg::CMD_ADDR && l_q.bitn != `TMR_BIT_COUNT) ||
                   (l_q.kind == tmr_pkg::CMD_RX && l_q.bitn == `TMR_BIT_COUNT))) begin
                l_d.sda_oe = 1'b0; // R3
                l_d.scl_oe = 1'b0;
                l_d.owns = 1'b0;
                l_d.lstat = `TMR_ST_ARB_LOST;
                finish = 1'b1;
              end
            end
            default: begin
              l_d.scl_oe = 1'b1;
              l_d.sh = {l_q.sh[7:0], 1'b1};
              l_d.bitn = l_q.bitn + 4'h1;
              if (l_q.bitn == `TMR_BIT_COUNT) begin
                l_d.sda_oe = 1'b0;
                finish = 1'b1; // R12
                if (l_q.kind == tmr_pkg::CMD_ADDR) begin
                  l_d.lstat = l_q.rsh[0] ? `TMR_ST_ADDR_NACK : `TMR_ST_ADDR_ACK; // R5 R6
                end else begin
                  l_d.lstat = l_q.ack ? `TMR_ST_DATA_ACK : `TMR_ST_DATA_NACK; // R7 R8
                end
              end
            end
          endcase
        end
      end
      tmr_pkg::LS_STOP: begin
        if (tick) begin
          case (l_q.phase)
            2'd0: l_d.sda_oe = 1'b1;
            2'd1: l_d.scl_oe = 1'b0;
            2'd2: l_d.sda_oe = 1'b0;
            default: begin
              l_d.owns = 1'b0;
              if (l_q.kind == tmr_pkg::CMD_STOP_START) begin
                l_d.st = tmr_pkg::LS_WAIT_FREE; // R10
              end else begin
                l_d.lstat = `TMR_ST_IDLE; // R9
                finish = 1'b1;
              end
            end
          endcase
        end
      end
      default: l_d.st = tmr_pkg::LS_IDLE;
    endcase
    if (finish) begin
      l_d.st = tmr_pkg::LS_IDLE;
      l_d.done_tgl = !l_q.done_tgl;
    end
    if (!l_q.rst_s) begin
      l_d = '{rst_m: l_d.rst_m, rst_s: l_d.rst_s, tg_m: l_d.tg_m, tg_s: l_d.tg_s, scl_m: l_d.scl_m,
              scl_s: l_d.scl_s, sda_m: l_d.sda_m, sda_s: l_d.sda_s, sda_p: l_d.sda_p,
              st: tmr_pkg::LS_IDLE, kind: tmr_pkg::CMD_NONE, sh: 9'h1ff, rsh: 9'h1ff,
              lstat: `TMR_STATUS_RST, default: '0};
    end
  end

  // the synchroniser fields (reset, toggle, clock and data lines) take no reset; the rest load reset values from its output
  always_ff @(posedge i_link_clk) begin
    l_q <= l_d;
  end

  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe = l_q.scl_oe;
  assign o_sda_oe = l_q.sda_oe;

endmodule

// File: verif/tmr_rx_sva.sv
// checker of the two-wire master receiver, watching its top-level ports only
// assumes the constants of tmr_map.svh and a synchronous active-low reset
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_rx_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ctl_write,
  input wire logic i_ctl_flag_clear,
  input wire logic i_ctl_ack,
  input wire logic i_ctl_enable,
  input wire logic i_data_write,
  input wire logic o_completion_flag,
  input wire logic [7:0] o_status,
  input wire logic [7:0] o_data,
  input wire logic o_ack_enable,
  input wire logic o_interface_enable,
  input wire logic o_transmitter_mode,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  flag_hold_a: assert property (o_completion_flag && !i_ctl_write |=> o_completion_flag)
    else $error("completion flag dropped without a write");
  flag_clear_a: assert property (i_ctl_write && i_ctl_flag_clear && o_completion_flag |=> !o_completion_flag)
    else $error("completion flag not cleared");
  bits_store_a: assert property (i_ctl_write && o_completion_flag |=>
    o_ack_enable == $past(i_ctl_ack) && o_interface_enable == $past(i_ctl_enable))
    else $error("control bits not stored");
  status_hold_a: assert property (o_completion_flag && !i_ctl_write |=> $stable(o_status))
    else $error("status moved while flag set");
  data_hold_a: assert property (o_completion_flag && !i_ctl_write && !i_data_write |=> $stable(o_data))
    else $error("data moved while flag set");
  status_legal_a: assert property (o_completion_flag |-> o_status inside {`TMR_ST_START, `TMR_ST_REP_START,
    `TMR_ST_ARB_LOST, `TMR_ST_ADDR_ACK, `TMR_ST_ADDR_NACK, `TMR_ST_DATA_ACK, `TMR_ST_DATA_NACK})
    else $error("undefined status with flag set");
  ack_sent_a: assert property ($rose(o_completion_flag) && o_status == `TMR_ST_DATA_ACK |-> o_ack_enable)
    else $error("acknowledge status without ack enable");
  nack_sent_a: assert property ($rose(o_completion_flag) && o_status == `TMR_ST_DATA_NACK |-> !o_ack_enable)
    else $error("not-acknowledge status with ack enable");
  lost_free_a: assert property ($rose(o_completion_flag) && o_status == `TMR_ST_ARB_LOST |->
    !o_sda_oe && !o_scl_oe)
    else $error("bus still driven after lost arbitration");
  tx_mode_a: assert property ($rose(o_transmitter_mode) |-> !o_data[`TMR_DIR_BIT] &&
    o_status inside {`TMR_ST_START, `TMR_ST_REP_START})
    else $error("transmitter mode without write address");
endmodule
bind tmr_master_rx tmr_rx_chk i_tmr_rx_chk (.i_ref_clk, .i_rst_n, .i_ctl_write, .i_ctl_flag_clear, .i_ctl_ack,
  .i_ctl_enable, .i_data_write, .o_completion_flag, .o_status, .o_data, .o_ack_enable, .o_interface_enable,
  .o_transmitter_mode, .o_scl_oe, .o_sda_oe);

// File: verif/tmr_slave_model.sv
// behavioural slave on the two-wire bus that sends bytes from a small table
// assumes resolved, pulled-up line levels; a rival input makes it steal the bus
`timescale 1ns/1ps
module tmr_slave_model #(
  parameter logic [6:0] ADDR = 7'h64
) (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_rival,
  output logic o_sda_oe
);
  // ****************************************************************
  // frame tracking
  // ****************************************************************
  logic [7:0] rom [0:3] = '{8'ha5, 8'h3c, 8'h81, 8'h5a};
  logic [7:0] sh = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic on = 0, adr = 0, tx = 0, drv = 0, hold = 0;
  int idx = 0;
  assign o_sda_oe = drv | hold;
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    on = 1;
    adr = 1;
    tx = 0;
    cnt = 4'h0;
    drv = 0;
  end
  always @(posedge i_sda) if (i_scl === 1'b1) begin
    on = 0;
    tx = 0;
    drv = 0;
  end
  // a rival master holds data low from the first address bit until told to let go
  always @(i_rival, i_scl) if (i_rival && on && adr && cnt == 4'h0 && i_scl === 1'b0) hold = 1;
  always @(negedge i_rival) hold = 0;
  always @(posedge i_scl) if (on) begin
    if (cnt < 4'h8) sh = {sh[6:0], i_sda};
    else if (tx) begin
      idx = idx + 1;
      tx = !i_sda;
    end
    cnt = cnt + 4'h1;
  end
  always @(negedge i_scl) if (on) begin
    if (cnt == 4'h9) begin
      cnt = 4'h0;
      if (adr) tx = (sh[7:1] == ADDR) && sh[0];
      adr = 0;
    end
    if (adr) drv = (cnt == 4'h8) && (sh[7:1] == ADDR);
    else drv = tx && cnt < 4'h8 && !rom[idx][3'd7 - cnt[2:0]];
  end
endmodule

// File: verif/test_two_wire_master_receiver.sv
// testbench of the two-wire master receiver driving its control ports like software
// assumes the slave model answers at address 64 and a pulled-up bus
`timescale 1ns/1ps
`include "tmr_map.svh"
module test_two_wire_master_receiver;
  logic i_ref_clk = 0, i_link_clk = 0, i_rst_n = 0, ctl_write = 0, ctl_clear = 0, ctl_start = 0;
  logic ctl_stop = 0, ctl_ack = 0, ctl_en = 0, data_write = 0, rx_ready = 0, rival = 0;
  logic [7:0] data_wdata = 8'h00;
  logic flag, start_q, stop_q, ack_q, en_q, tx_mode, rx_valid, scl_oe, sda_oe, slv_oe, scl_out, sda_out;
  logic [7:0] status, data, rx_data;
  wire logic scl_w, sda_w;
  int err_total = 0, n_compared = 0, cycles = 0, k;
  assign scl_w = ~scl_oe;
  assign sda_w = ~(sda_oe | slv_oe);
  always #2.5 i_ref_clk = ~i_ref_clk;
  initial begin
    #3.1;
    forever #7.5 i_link_clk = ~i_link_clk;
  end
  tmr_master_rx i_tmr_master_rx (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_link_clk(i_link_clk),
    .i_ctl_write(ctl_write), .i_ctl_flag_clear(ctl_clear), .i_ctl_start(ctl_start), .i_ctl_stop(ctl_stop),
    .i_ctl_ack(ctl_ack), .i_ctl_enable(ctl_en), .i_data_write(data_write), .i_data_wdata(data_wdata),
    .o_completion_flag(flag), .o_status(status), .o_data(data), .o_start_request(start_q),
    .o_stop_request(stop_q), .o_ack_enable(ack_q), .o_interface_enable(en_q), .o_transmitter_mode(tx_mode),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready), .i_scl(scl_w), .o_scl_out(scl_out),
    .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe));
  tmr_slave_model i_tmr_slave_model (.i_scl(scl_w), .i_sda(sda_w), .i_rival(rival), .o_sda_oe(slv_oe));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic ctl(input logic start_request_bit, input logic stop_request_bit, input logic ack, input logic en = 1'b1);
    @(posedge i_ref_clk);
    {ctl_write, ctl_clear, ctl_en, ctl_start, ctl_stop, ctl_ack} <= {2'b11, en, start_request_bit, stop_request_bit, ack};
    @(posedge i_ref_clk);
    ctl_write <= 0;
    @(posedge i_ref_clk);
  endtask
  task automatic load(input logic [7:0] b);
    @(posedge i_ref_clk);
    {data_write, data_wdata} <= {1'b1, b};
    @(posedge i_ref_clk);
    data_write <= 0;
  endtask
  // m selects what ends the wait: 0 the flag, 1 a status code, 2 transmitter mode
  task automatic wait_for(input int m, input logic [7:0] code);
    int n;
    n = 0;
    while (!(m == 0 ? flag === 1'b1 : m == 1 ? status === code : tx_mode === 1'b1) && n < 9000) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n == 9000) chk("wait", 8'h00, 8'h01);
  endtask
  task automatic step(input logic start_request_bit, input logic stop_request_bit, input logic ack, input logic [7:0] code);
    ctl(start_request_bit, stop_request_bit, ack);
    wait_for(0, code);
    chk("status", code, status);
  endtask
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1;
    @(negedge i_ref_clk);
    chk("status", `TMR_ST_IDLE, status);
    chk("data", 8'hff, data);
    step(1, 0, 0, `TMR_ST_START);
    chk("start request", 8'h01, {7'h00, start_q});
    chk("enable", 8'h01, {7'h00, en_q});
    load(8'hc9);
    rival <= 1;
    step(0, 0, 0, `TMR_ST_ARB_LOST);
    ctl(1, 0, 0);
    repeat (3000) @(posedge i_ref_clk);
    chk("flag", 8'h00, {7'h00, flag});
    rival <= 0;
    wait_for(0, 8'h00);
    chk("status", `TMR_ST_START, status);
    load(8'hc9);
    rival <= 1;
    step(0, 0, 0, `TMR_ST_ARB_LOST);
    ctl(0, 0, 0);
    wait_for(1, `TMR_ST_IDLE);
    chk("bus drive", 8'h00, {4'h0, scl_out, sda_out, scl_oe, sda_oe});
    rival <= 0;
    $display("test arbitration done");
    step(1, 0, 0, `TMR_ST_START);
    load(8'h41);
    step(0, 0, 0, `TMR_ST_ADDR_NACK);
    step(1, 0, 0, `TMR_ST_REP_START);
    load(8'hc9);
    step(0, 0, 0, `TMR_ST_ADDR_ACK);
    step(0, 0, 1, `TMR_ST_DATA_ACK);
    chk("ack enable", 8'h01, {7'h00, ack_q});
    chk("data", 8'ha5, data);
    step(0, 0, 0, `TMR_ST_DATA_NACK);
    chk("data", 8'h3c, data);
    step(1, 1, 0, `TMR_ST_START);
    chk("stop request", 8'h00, {7'h00, stop_q});
    $display("test read done");
    load(8'hc9);
    step(0, 0, 0, `TMR_ST_ADDR_ACK);
    step(0, 0, 0, `TMR_ST_DATA_NACK);
    chk("data", 8'h81, data);
    ctl(0, 1, 0);
    wait_for(1, `TMR_ST_IDLE);
    chk("stop request", 8'h00, {7'h00, stop_q});
    chk("flag", 8'h00, {7'h00, flag});
    ctl(0, 0, 1, 0);
    chk("enable", 8'h00, {7'h00, en_q});
    chk("ack enable", 8'h01, {7'h00, ack_q});
    chk("status", `TMR_ST_IDLE, status);
    $display("test stop done");
    step(1, 0, 0, `TMR_ST_START);
    load(8'hc8);
    ctl(0, 0, 0);
    wait_for(2, 8'h00);
    chk("transmitter mode", 8'h01, {7'h00, tx_mode});
    $display("test handover done");
    @(posedge i_ref_clk);
    rx_ready <= 1;
    k = 0;
    for (int n = 0; n < 100 && k < 3; n++) begin
      @(negedge i_ref_clk);
      if (rx_valid === 1'b1) begin
        chk("stream", k == 0 ? 8'ha5 : k == 1 ? 8'h3c : 8'h81, rx_data);
        k++;
      end
    end
    chk("stream count", 8'h03, k[7:0]);
    @(negedge i_ref_clk);
    chk("stream empty", 8'h00, {7'h00, rx_valid});
    $display("test stream done");
    report_and_stop();
  end
endmodule
